// file: rtl/port_pin_mux_rmw_map.vh
// Purpose: Register offsets, fields and reset values of the port pin mux
// Assumes: AXI4-Lite byte addresses, one aligned 32-bit word per register
// Notes: Definitions only
`ifndef PORT_PIN_MUX_RMW_MAP_VH
`define PORT_PIN_MUX_RMW_MAP_VH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define OFS_LATCH0 8'h00
`define OFS_LATCH1 8'h04
`define OFS_LATCH3 8'h08
`define OFS_LATCH4 8'h0c
`define OFS_PIN0 8'h10
`define OFS_PIN1 8'h14
`define OFS_PIN2 8'h18
`define OFS_PIN3 8'h1c
`define OFS_PIN4 8'h20
`define OFS_PWM_EN 8'h24
`define OFS_ADC_CTRL 8'h28
`define OFS_SETUP_ONE 8'h2c
`define OFS_RMW_CMD 8'h30

// ---------------------------------------------------------------
// Fields and reset values
// ---------------------------------------------------------------
`define LATCH_RESET 8'hff
`define CTRL_RESET 8'h00
`define SETUP_RW_STROBE_BIT 0
`define CMD_OP_LSB 0
`define CMD_PORT_LSB 4
`define CMD_BIT_LSB 8
`define CMD_OPERAND_LSB 16
`define CMD_CARRY_BIT 24
`define CMD_FLAG_BIT 8

// ---------------------------------------------------------------
// Read-modify-write operation codes
// ---------------------------------------------------------------
`define OP_AND 4'h0
`define OP_OR 4'h1
`define OP_XOR 4'h2
`define OP_JUMP_BIT_CLEAR 4'h3
`define OP_COMPLEMENT_BIT 4'h4
`define OP_INC 4'h5
`define OP_DEC 4'h6
`define OP_DEC_JUMP_NONZERO 4'h7
`define OP_MOVE_CARRY_BIT 4'h8
`define OP_CLEAR_BIT 4'h9
`define OP_SET_BIT 4'ha

// ---------------------------------------------------------------
// Bus responses
// ---------------------------------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// file: rtl/port_rmw_alu.v
// Purpose: Modify step of a port read-modify-write operation
// Assumes: The value read is always the output latch, never the pin
// Notes: Purely combinational
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_mux_rmw_map.vh"

module port_rmw_alu (
	// Operation
	input wire [3:0] op,
	input wire [2:0] bit_sel,
	input wire [7:0] operand,
	input wire carry_in,
	// Latch contents
	input wire [7:0] latch_val,
	// Result
	output reg [7:0] result,
	output reg flag,
	output reg op_valid
);

	// ---------------------------------------------------------------
	// Modify
	// ---------------------------------------------------------------
	// Bit operations keep the other seven latch bits as read
	always @* begin
		result = latch_val;
		flag = 1'b0;
		op_valid = 1'b1;
		case (op)
			`OP_AND: result = latch_val & operand;
			`OP_OR: result = latch_val | operand;
			`OP_XOR: result = latch_val ^ operand;
			`OP_JUMP_BIT_CLEAR: begin
				flag = latch_val[bit_sel];
				result[bit_sel] = 1'b0;
			end
			`OP_COMPLEMENT_BIT: result[bit_sel] = ~latch_val[bit_sel];
			`OP_INC: result = latch_val + 8'h01;
			`OP_DEC: result = latch_val - 8'h01;
			`OP_DEC_JUMP_NONZERO: begin
				result = latch_val - 8'h01;
				flag = (latch_val != 8'h01);
			end
			`OP_MOVE_CARRY_BIT: result[bit_sel] = carry_in;
			`OP_CLEAR_BIT: result[bit_sel] = 1'b0;
			`OP_SET_BIT: result[bit_sel] = 1'b1;
			default: op_valid = 1'b0;
		endcase
	end

endmodule
`default_nettype wire

// file: rtl/port_pin_mux_rmw.v
// Purpose: Port latches, pin multiplexing and latch read-modify-write
// Assumes: Pin inputs synchronous to clk_sys; AXI4-Lite register access
// Notes: Pin outputs and alternate inputs are registered, one cycle late
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_mux_rmw_map.vh"

module port_pin_mux_rmw #(
	parameter ADDR_WIDTH = 8
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// AXI4-Lite write address and data
	input wire [ADDR_WIDTH-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read
	input wire [ADDR_WIDTH-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Port pins
	input wire [7:0] port_zero_in,
	output reg [7:0] port_zero_out,
	output reg [7:0] port_zero_oe,
	input wire [7:0] port_one_in,
	output reg [7:0] port_one_out,
	output reg [7:0] port_one_oe,
	input wire [3:0] port_two_in,
	input wire [7:0] port_three_in,
	output reg [7:0] port_three_out,
	output reg [7:0] port_three_oe,
	input wire [7:0] port_four_in,
	output reg [7:0] port_four_out,
	output reg [7:0] port_four_oe,
	// Alternate function sources
	input wire [5:0] pwm8_in,
	input wire [1:0] pwm14_in,
	input wire serial_tx,
	input wire read_strobe_n,
	input wire write_strobe_n,
	// Alternate function sinks
	output reg ext_int0_n,
	output reg ext_int1_n,
	output reg ext_extra_int0_n,
	output reg ext_extra_int1_n,
	output reg timer0_count,
	output reg timer1_count,
	output reg serial_rx,
	output reg [3:0] converter_in,
	output reg [3:0] converter_sel
);

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	reg [7:0] port_zero_reg, port_one_reg, port_three_reg, port_four_reg;
	reg [7:0] prev_one_reg, prev_three_reg, prev_four_reg;
	reg [7:0] pulse_width_enable_reg, rmw_result_reg, rmw_latch;
	reg [3:0] converter_channel_ctrl, w_strb_reg;
	reg rw_strobe_enable, rmw_flag_reg, aw_held_reg, w_held_reg, rmw_port_ok;
	reg [ADDR_WIDTH-1:0] aw_addr_reg;
	reg [31:0] w_data_reg;
	wire [7:0] rmw_result;
	wire rmw_flag, rmw_op_ok;
	reg [7:0] one_val, one_drive, three_val, three_drive, four_val, four_drive;

	// Known register offsets, shared by write and read decode
	function addr_known;
		input [ADDR_WIDTH-1:0] a;
		begin
			case (a[7:0])
				`OFS_LATCH0, `OFS_LATCH1, `OFS_LATCH3, `OFS_LATCH4, `OFS_PIN0, `OFS_PIN1,
				`OFS_PIN2, `OFS_PIN3, `OFS_PIN4, `OFS_PWM_EN, `OFS_ADC_CTRL,
				`OFS_SETUP_ONE, `OFS_RMW_CMD: addr_known = ((a >> 8) == {ADDR_WIDTH{1'b0}});
				default: addr_known = 1'b0;
			endcase
		end
	endfunction

	// ---------------------------------------------------------------
	// Bus handshake
	// ---------------------------------------------------------------
	// One write in flight; both channels may arrive in either order
	assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_held_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;

	// ---------------------------------------------------------------
	// Read-modify-write operand select
	// ---------------------------------------------------------------
	// latch not pin
	always @* begin
		rmw_port_ok = 1'b1;
		case (w_data_reg[`CMD_PORT_LSB+2:`CMD_PORT_LSB])
			3'd0: rmw_latch = port_zero_reg;
			3'd1: rmw_latch = port_one_reg;
			3'd3: rmw_latch = port_three_reg;
			3'd4: rmw_latch = port_four_reg;
			default: begin
				rmw_latch = 8'hff;
				rmw_port_ok = 1'b0;
			end
		endcase
	end

	port_rmw_alu u_alu (
		.op(w_data_reg[`CMD_OP_LSB+3:`CMD_OP_LSB]),
		.bit_sel(w_data_reg[`CMD_BIT_LSB+2:`CMD_BIT_LSB]),
		.operand(w_data_reg[`CMD_OPERAND_LSB+7:`CMD_OPERAND_LSB]),
		.carry_in(w_data_reg[`CMD_CARRY_BIT]),
		.latch_val(rmw_latch),
		.result(rmw_result),
		.flag(rmw_flag),
		.op_valid(rmw_op_ok)
	);

	// ---------------------------------------------------------------
	// Write path and latches
	// ---------------------------------------------------------------
	// Execute one edge after both channels are held
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= {ADDR_WIDTH{1'b0}};
			w_data_reg <= 32'h00000000;
			w_strb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
			port_zero_reg <= `LATCH_RESET;
			port_one_reg <= `LATCH_RESET;
			port_three_reg <= `LATCH_RESET;
			port_four_reg <= `LATCH_RESET;
			pulse_width_enable_reg <= `CTRL_RESET;
			converter_channel_ctrl <= 4'h0;
			rw_strobe_enable <= 1'b0;
			rmw_result_reg <= 8'h00;
			rmw_flag_reg <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
			if (aw_held_reg && w_held_reg) begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= `RESP_OKAY;
				if (!addr_known(aw_addr_reg))
					s_axi_bresp <= `RESP_SLVERR;
				else if (aw_addr_reg[7:0] == `OFS_RMW_CMD) begin
					if (rmw_port_ok && rmw_op_ok && w_strb_reg[0]) begin
						rmw_result_reg <= rmw_result;
						rmw_flag_reg <= rmw_flag;
						case (w_data_reg[`CMD_PORT_LSB+2:`CMD_PORT_LSB])
							3'd0: port_zero_reg <= rmw_result;
							3'd1: port_one_reg <= rmw_result;
							3'd3: port_three_reg <= rmw_result;
							default: port_four_reg <= rmw_result;
						endcase
					end else
						s_axi_bresp <= `RESP_SLVERR;
				end else if (w_strb_reg[0]) begin
					// Plain stores; pin views ignore writes
					case (aw_addr_reg[7:0])
						`OFS_LATCH0: port_zero_reg <= w_data_reg[7:0];
						`OFS_LATCH1: port_one_reg <= w_data_reg[7:0];
						`OFS_LATCH3: port_three_reg <= w_data_reg[7:0];
						`OFS_LATCH4: port_four_reg <= w_data_reg[7:0];
						`OFS_PWM_EN: pulse_width_enable_reg <= w_data_reg[7:0];
						`OFS_ADC_CTRL: converter_channel_ctrl <= w_data_reg[3:0];
						`OFS_SETUP_ONE: rw_strobe_enable <= w_data_reg[`SETUP_RW_STROBE_BIT];
						default: rw_strobe_enable <= rw_strobe_enable;
					endcase
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Read path
	// ---------------------------------------------------------------
	// Pin views of ports 0, 1, 3 and 4 read latch AND pin, so a driven zero reads zero; port 2 reads the pin alone
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= addr_known(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
			s_axi_rdata <= 32'h00000000;
			if (addr_known(s_axi_araddr)) begin
				case (s_axi_araddr[7:0])
					`OFS_LATCH0: s_axi_rdata[7:0] <= port_zero_reg;
					`OFS_LATCH1: s_axi_rdata[7:0] <= port_one_reg;
					`OFS_LATCH3: s_axi_rdata[7:0] <= port_three_reg;
					`OFS_LATCH4: s_axi_rdata[7:0] <= port_four_reg;
					`OFS_PIN0: s_axi_rdata[7:0] <= port_zero_reg & port_zero_in;
					`OFS_PIN1: s_axi_rdata[7:0] <= port_one_reg & port_one_in;
					`OFS_PIN2: s_axi_rdata[3:0] <= port_two_in;
					`OFS_PIN3: s_axi_rdata[7:0] <= port_three_reg & port_three_in;
					`OFS_PIN4: s_axi_rdata[7:0] <= port_four_reg & port_four_in;
					`OFS_PWM_EN: s_axi_rdata[7:0] <= pulse_width_enable_reg;
					`OFS_ADC_CTRL: s_axi_rdata[3:0] <= converter_channel_ctrl;
					`OFS_SETUP_ONE: s_axi_rdata[`SETUP_RW_STROBE_BIT] <= rw_strobe_enable;
					default: s_axi_rdata[8:0] <= {rmw_flag_reg, rmw_result_reg};
				endcase
			end
		end else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Output multiplexing
	// ---------------------------------------------------------------
	// Drive level and strong-drive mask per pin
	always @* begin
		one_val = (pulse_width_enable_reg & {pwm14_in, pwm8_in}) | (~pulse_width_enable_reg & port_one_reg);
		one_drive = pulse_width_enable_reg;
		three_val = port_three_reg;
		three_val[1] = port_three_reg[1] | serial_tx;
		three_drive = {6'h00, ~port_three_reg[1], 1'b0};
		four_val = port_four_reg;
		four_val[3:2] = rw_strobe_enable ? {write_strobe_n, read_strobe_n} : port_four_reg[3:2];
		four_drive = {4'h0, rw_strobe_enable, rw_strobe_enable, 2'b00};
	end

	// Quasi-bidirectional pins pull latch zeros low, release latch ones and
	// source current for one cycle after a latch zero-to-one change
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			prev_one_reg <= `LATCH_RESET;
			prev_three_reg <= `LATCH_RESET;
			prev_four_reg <= `LATCH_RESET;
			port_zero_out <= 8'h00;
			port_zero_oe <= 8'h00;
			port_one_out <= 8'hff;
			port_one_oe <= 8'h00;
			port_three_out <= 8'hff;
			port_three_oe <= 8'h00;
			port_four_out <= 8'hff;
			port_four_oe <= 8'h00;
		end else begin
			prev_one_reg <= port_one_reg;
			prev_three_reg <= port_three_reg;
			prev_four_reg <= port_four_reg;
			// Open drain: a one floats the pin
			port_zero_out <= 8'h00;
			port_zero_oe <= ~port_zero_reg;
			port_one_out <= one_val;
			port_one_oe <= ~one_val | one_drive | (port_one_reg & ~prev_one_reg);
			port_three_out <= three_val;
			port_three_oe <= ~three_val | three_drive | (port_three_reg & ~prev_three_reg);
			port_four_out <= four_val;
			port_four_oe <= ~four_val | four_drive | (port_four_reg & ~prev_four_reg);
		end
	end

	// ---------------------------------------------------------------
	// Alternate inputs
	// ---------------------------------------------------------------
	// Outside input mode each source idles at its inactive level
	always @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			ext_extra_int0_n <= 1'b1;
			ext_int0_n <= 1'b1;
			ext_int1_n <= 1'b1;
			timer0_count <= 1'b0;
			timer1_count <= 1'b0;
			ext_extra_int1_n <= 1'b1;
			serial_rx <= 1'b1;
			converter_in <= 4'h0;
			converter_sel <= 4'h0;
		end else begin
			ext_extra_int0_n <= port_three_reg[1] ? port_three_in[1] : 1'b1;
			ext_int0_n <= port_three_reg[2] ? port_three_in[2] : 1'b1;
			ext_int1_n <= port_three_reg[3] ? port_three_in[3] : 1'b1;
			timer0_count <= port_three_reg[4] & port_three_in[4];
			timer1_count <= port_three_reg[5] & port_three_in[5];
			ext_extra_int1_n <= port_three_reg[7] ? port_three_in[7] : 1'b1;
			serial_rx <= port_three_reg[7] ? port_three_in[7] : 1'b1;
			converter_in <= port_two_in & converter_channel_ctrl;
			converter_sel <= converter_channel_ctrl;
		end
	end

endmodule
`default_nettype wire

// file: testbench/port_pin_mux_rmw_asserts.sv
// Purpose: Port-level checks of the pin mux outputs
// Assumes: Pin side outputs lag their causes by one clock
// Notes: Latch state is seen through the port outputs
`timescale 1ns/100ps
`default_nettype none
module port_pin_mux_rmw_asserts (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Bus answers
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// Pins and alternate sinks
	input wire logic [3:0] port_two_in,
	input wire logic [7:0] port_three_in,
	input wire logic [7:0] port_three_out,
	input wire logic [7:0] port_zero_out,
	input wire logic [7:0] port_zero_oe,
	input wire logic ext_int0_n,
	input wire logic ext_int1_n,
	input wire logic ext_extra_int1_n,
	input wire logic timer0_count,
	input wire logic timer1_count,
	input wire logic serial_rx,
	input wire logic [3:0] converter_in,
	input wire logic [3:0] converter_sel
);
	// ----------------
	// Properties
	// ----------------
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	// Outputs still hold reset values one edge after release
	sequence s_run; !$past(rst); endsequence
	property p_int0; s_run |-> ext_int0_n == (port_three_out[2] ? $past(port_three_in[2]) : 1'b1); endproperty
	a_int0: assert property (p_int0) else $error("int0 wrong");
	property p_int1; s_run |-> ext_int1_n == (port_three_out[3] ? $past(port_three_in[3]) : 1'b1); endproperty
	a_int1: assert property (p_int1) else $error("int1 wrong");
	property p_tmr0; s_run |-> timer0_count == ($past(port_three_in[4]) & port_three_out[4]); endproperty
	a_tmr0: assert property (p_tmr0) else $error("timer0 wrong");
	property p_tmr1; s_run |-> timer1_count == ($past(port_three_in[5]) & port_three_out[5]); endproperty
	a_tmr1: assert property (p_tmr1) else $error("timer1 wrong");
	property p_rx; s_run |-> serial_rx == (port_three_out[7] ? $past(port_three_in[7]) : 1'b1); endproperty
	a_rx: assert property (p_rx) else $error("receive wrong");
	property p_xint1; s_run |-> ext_extra_int1_n == (port_three_out[7] ? $past(port_three_in[7]) : 1'b1); endproperty
	a_xint1: assert property (p_xint1) else $error("extra int1 wrong");
	property p_conv; s_run |-> converter_in == ($past(port_two_in) & converter_sel); endproperty
	a_conv: assert property (p_conv) else $error("converter wrong");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("rvalid dropped");
	// Second edge after release: pins follow the reset latches
	property p_zero;
		$past(rst, 2) && !$past(rst) |-> port_zero_out == 8'h00 && port_zero_oe == 8'h00 && port_three_out == 8'hff;
	endproperty
	a_zero: assert property (p_zero) else $error("latches not reset");
endmodule
bind port_pin_mux_rmw port_pin_mux_rmw_asserts chk (.*);
`default_nettype wire

// file: testbench/board_pins.sv
// Purpose: Board circuit on one port's pins
// Assumes: Pull-up on every pin
// Notes: Device drive wins over the board
`timescale 1ns/100ps
`default_nettype none
module board_pins (
	// Device side
	input wire logic [7:0] out,
	input wire logic [7:0] oe,
	// Board drive
	input wire logic [7:0] drv_en,
	input wire logic [7:0] drv_val,
	// Pin level
	output logic [7:0] pin
);
	// Released lines float up, never keep a stale level
	assign pin = (oe & out) | (~oe & ((drv_en & drv_val) | ~drv_en));
endmodule
`default_nettype wire

// file: testbench/test_port_pin_mux_rmw.sv
// Purpose: Self-checking bench for the port pin mux
// Assumes: Board pull-ups on released pins
// Notes: Register reads checked against queued notes
`timescale 1ns/100ps
`default_nettype none
`include "port_pin_mux_rmw_map.vh"
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin bad_count++; $display("ERROR %s exp %h got %h", n, e, s); end end
`define WAIT(c) n = 0; do begin @(negedge clk_sys); n++; end while (!(c) && n < 50); if (!(c)) begin `CHK("wait", 1'b1, 1'b0) results(); end
module test_port_pin_mux_rmw;
	// ----------------
	// Wiring
	// ----------------
	logic clk_sys = 0, rst = 1;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, v;
	logic [31:0] s_axi_wdata = 0, r, c;
	logic [3:0] s_axi_wstrb = 4'hf, port_two_in = 0;
	logic [5:0] pwm8_in = 0;
	logic [1:0] pwm14_in = 0, b;
	logic serial_tx = 0, read_strobe_n = 1, write_strobe_n = 1;
	logic [7:0] de [4] = '{default: 0}, dv [4] = '{default: 0};
	logic [33:0] e, exp_q [$];
	logic [1:0] bq [$];
	logic [8:0] x;
	int bad_count = 0, samples_checked = 0, k;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [7:0] port_zero_in, port_zero_out, port_zero_oe, port_one_in, port_one_out, port_one_oe;
	wire [7:0] port_three_in, port_three_out, port_three_oe, port_four_in, port_four_out, port_four_oe;
	wire ext_int0_n, ext_int1_n, ext_extra_int0_n, ext_extra_int1_n, timer0_count, timer1_count, serial_rx;
	wire [3:0] converter_in, converter_sel;
	port_pin_mux_rmw dut (.*);
	board_pins b0 (.out(port_zero_out), .oe(port_zero_oe), .drv_en(de[0]), .drv_val(dv[0]), .pin(port_zero_in));
	board_pins b1 (.out(port_one_out), .oe(port_one_oe), .drv_en(de[1]), .drv_val(dv[1]), .pin(port_one_in));
	board_pins b3 (.out(port_three_out), .oe(port_three_oe), .drv_en(de[2]), .drv_val(dv[2]), .pin(port_three_in));
	board_pins b4 (.out(port_four_out), .oe(port_four_oe), .drv_en(de[3]), .drv_val(dv[3]), .pin(port_four_in));
	// 40 MHz clock
	initial forever #12.5 clk_sys = ~clk_sys;
	// Each bus answer against the oldest note
	always @(posedge clk_sys) begin
		if (s_axi_rvalid && s_axi_rready) begin
			e = exp_q.pop_front();
			`CHK("read", e, {s_axi_rresp, s_axi_rdata})
		end
		if (s_axi_bvalid && s_axi_bready) begin
			b = bq.pop_front();
			`CHK("bresp", b, s_axi_bresp)
		end
	end
	// ----------------
	// Tasks
	// ----------------
	task automatic results;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// Ready raised late so the answer has to stand
	task automatic wr(input [7:0] a, input [31:0] d, input [1:0] rs);
		int n;
		bq.push_back(rs);
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		`WAIT(s_axi_awready && s_axi_wready)
		@(posedge clk_sys);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		`WAIT(s_axi_bvalid)
		@(posedge clk_sys) s_axi_bready <= 1;
		@(posedge clk_sys) s_axi_bready <= 0;
	endtask
	task automatic rd(input [7:0] a, input [33:0] ex);
		int n;
		exp_q.push_back(ex);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		`WAIT(s_axi_arready)
		@(posedge clk_sys) s_axi_arvalid <= 0;
		`WAIT(s_axi_rvalid)
		@(posedge clk_sys) s_axi_rready <= 1;
		@(posedge clk_sys) s_axi_rready <= 0;
	endtask
	task automatic settle;
		repeat (2) @(posedge clk_sys);
		@(negedge clk_sys);
	endtask
	// Reference {flag, result} of one latch operation
	function automatic logic [8:0] rmw(input [3:0] op, input [2:0] bt, input [7:0] l, input [7:0] o, input cy);
		logic [7:0] m;
		m = 8'h01 << bt;
		case (op)
			0: rmw = {1'b0, l & o};
			1: rmw = {1'b0, l | o};
			2: rmw = {1'b0, l ^ o};
			3: rmw = {l[bt], l & ~m};
			4: rmw = {1'b0, l ^ m};
			5: rmw = {1'b0, l + 8'h01};
			6: rmw = {1'b0, l - 8'h01};
			7: rmw = {l != 8'h01, l - 8'h01};
			8: rmw = {1'b0, cy ? l | m : l & ~m};
			9: rmw = {1'b0, l & ~m};
			default: rmw = {1'b0, l | m};
		endcase
	endfunction
	// ----------------
	// Scenarios
	// ----------------
	initial begin
		k = $urandom(72);
		repeat (6) @(posedge clk_sys);
		rst <= 0;
		for (k = 0; k < 4; k++) rd(8'(k * 4), 34'hff);
		rd(8'h3c, {`RESP_SLVERR, 32'h0});
		wr(8'h3c, 32'h0, `RESP_SLVERR);
		// Board pulls port one low so pins and latch disagree
		de[1] <= 8'hff;
		r = $urandom;
		v = r[7:0];
		wr(`OFS_LATCH1, {24'h0, v}, `RESP_OKAY);
		rd(`OFS_PIN1, 34'h0);
		for (k = 0; k <= 10; k++) begin
			c = ($urandom & 32'h01ff_0700) | 32'h10 | k;
			x = rmw(k[3:0], c[10:8], v, c[23:16], c[24]);
			wr(`OFS_RMW_CMD, c, `RESP_OKAY);
			v = x[7:0];
			rd(`OFS_LATCH1, {26'h0, v});
			if (k == 3 || k == 7) rd(`OFS_RMW_CMD, {25'h0, x});
		end
		wr(`OFS_RMW_CMD, 32'h21, `RESP_SLVERR);
		wr(`OFS_RMW_CMD, 32'h1b, `RESP_SLVERR);
		rd(`OFS_LATCH1, {26'h0, v});
		// PWM on a random subset of port one
		r = $urandom;
		{pwm14_in, pwm8_in} <= r[7:0];
		wr(`OFS_PWM_EN, {24'h0, r[15:8]}, `RESP_OKAY);
		settle();
		`CHK("pwm", {r[15:8], r[7:0] & r[15:8]}, {port_one_oe & r[15:8], port_one_out & r[15:8]})
		`CHK("plain", v & ~r[15:8], port_one_out & ~r[15:8])
		// Port three inputs while latch holds ones
		@(posedge clk_sys);
		r = $urandom;
		de[2] <= 8'hff;
		dv[2] <= r[7:0];
		settle();
		c = {r[7], r[7], r[5], r[4], r[3], r[2], r[1]};
		`CHK("alt in", c[6:0], {serial_rx, ext_extra_int1_n, timer1_count, timer0_count, ext_int1_n, ext_int0_n, ext_extra_int0_n})
		@(posedge clk_sys) serial_tx <= r[9];
		wr(`OFS_LATCH3, 32'h0, `RESP_OKAY);
		settle();
		`CHK("alt idle", 7'h67, {serial_rx, ext_extra_int1_n, timer1_count, timer0_count, ext_int1_n, ext_int0_n, ext_extra_int0_n})
		`CHK("transmit", {1'b1, r[9]}, {port_three_oe[1], port_three_out[1]})
		// Converter routing and strobes
		@(posedge clk_sys) port_two_in <= r[13:10];
		read_strobe_n <= r[14];
		write_strobe_n <= r[15];
		wr(`OFS_ADC_CTRL, 32'h5, `RESP_OKAY);
		wr(`OFS_SETUP_ONE, 32'h1, `RESP_OKAY);
		settle();
		`CHK("converter", {4'h5, r[13:10] & 4'h5}, {converter_sel, converter_in})
		`CHK("strobes", {2'h3, r[15:14]}, {port_four_oe[3:2], port_four_out[3:2]})
		rd(`OFS_PIN2, {30'h0, r[13:10]});
		wr(`OFS_SETUP_ONE, 32'h0, `RESP_OKAY);
		settle();
		`CHK("strobes off", 2'h3, port_four_out[3:2])
		// Latch operations on ports zero, three and four
		wr(`OFS_RMW_CMD, 32'h005a_0000, `RESP_OKAY);
		wr(`OFS_RMW_CMD, 32'h0000_023a, `RESP_OKAY);
		wr(`OFS_RMW_CMD, 32'h0000_0349, `RESP_OKAY);
		rd(`OFS_LATCH0, 34'h5a);
		rd(`OFS_PIN0, 34'h5a);
		rd(`OFS_LATCH3, 34'h04);
		rd(`OFS_LATCH4, 34'hf7);
		// Second reset restores the latches
		@(posedge clk_sys) rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		rd(`OFS_LATCH1, 34'hff);
		rd(`OFS_LATCH0, 34'hff);
		repeat (2) @(posedge clk_sys);
		results();
	end
endmodule
`default_nettype wire
